// ===== core/alpm_ctrl.sv
// alpm_ctrl: light-sleep and deep-sleep power mode control
// Contract
// R1: normal mode keeps circuits powered between conversions
// R2: host unlocks with 69h at 05h first
// R3: light sleep at conversion end, pin high
// R4: light sleep holds blocks reduced-power in acquisition
// R5: pin falling edge leaves light sleep
// R6: host waits light-sleep wake time before start
// R7: deep request enters deep on pin rise
// R8: deep: analog off, interface on, registers kept
// R9: deep sleep drives ready status high
// R10: host clears deep request to leave
// R11: clearing request drives ready high, power-up begins
// R12: host waits deep power-up time before converting
// R13: wake times are cycle-count parameters
`timescale 1ns/1ns
`default_nettype none
module alpm_ctrl
#(
  parameter int LIGHT_WAKE = alpm_pkg::LIGHT_WAKE_CYC, // R13
  parameter int DEEP_WAKE = alpm_pkg::DEEP_WAKE_CYC
)
(
  // clock and reset
  input wire logic i_clock,
  input wire logic i_reset,
  // pin and conversion core
  input wire logic i_conversion_start_select,
  input wire logic i_conversion_done,
  // register write port from serial interface
  input wire logic i_reg_write,
  input wire logic [alpm_pkg::ADDR_W-1:0] i_reg_addr,
  input wire logic [alpm_pkg::DATA_W-1:0] i_reg_wdata,
  // power and status outputs
  output logic o_analog_power_on,
  output logic o_reduced_power,
  output logic o_interface_on,
  output logic o_ready_status_output,
  output logic o_wake_pending,
  output logic o_light_sleep_enable,
  output logic o_deep_sleep_request
);
  logic css_s;
  logic css_d_r;
  logic css_rise;
  logic css_fall;
  logic unlock_r;
  logic unlock_nxt;
  logic light_en_r;
  logic light_en_nxt;
  logic deep_req_r;
  logic deep_req_nxt;
  logic ctl_wr;
  alpm_pkg::alpm_state_t state_r;
  alpm_pkg::alpm_state_t state_nxt;
  logic [alpm_pkg::CNT_W-1:0] cnt_r;
  logic [alpm_pkg::CNT_W-1:0] cnt_nxt;
  logic analog_r;
  logic analog_nxt;
  logic reduced_r;
  logic reduced_nxt;
  logic ready_r;
  logic ready_nxt;
  logic wake_r;
  logic wake_nxt;
  logic interface_r;
  logic interface_nxt;

  // ==========================================================================
  // pin synchronisation and edge detect
  // ==========================================================================
  alpm_sync alpm_sync_i
  (
    .i_clock(i_clock),
    .i_reset(i_reset),
    .i_async(i_conversion_start_select),
    .o_sync(css_s)
  );
  always_ff @(posedge i_clock or posedge i_reset)
  begin
    if (i_reset)
      css_d_r <= 1'b0;
    else
      css_d_r <= css_s;
  end
  assign css_rise = css_s & ~css_d_r;
  assign css_fall = ~css_s & css_d_r;

  // ==========================================================================
  // power control word with unlock; registers stay intact in deep sleep
  // ==========================================================================
  // the unlock is one-shot: any other write relocks, so a stray write cannot
  // flip a power bit
  always_comb
  begin
    unlock_nxt = unlock_r;
    light_en_nxt = light_en_r;
    deep_req_nxt = deep_req_r;
    ctl_wr = i_reg_write && (i_reg_addr == alpm_pkg::PWR_CTL_ADDR) && unlock_r; // R2
    if (i_reg_write)
    begin
      unlock_nxt = (i_reg_addr == alpm_pkg::UNLOCK_ADDR) &&
                   (i_reg_wdata == alpm_pkg::UNLOCK_VALUE); // R2
      if (ctl_wr)
      begin
        light_en_nxt = i_reg_wdata[alpm_pkg::LIGHT_EN_BIT];
        deep_req_nxt = i_reg_wdata[alpm_pkg::DEEP_REQ_BIT];
      end
    end
  end
  always_ff @(posedge i_clock or posedge i_reset)
  begin
    if (i_reset)
    begin
      unlock_r <= 1'b0;
      light_en_r <= 1'b0;
      deep_req_r <= 1'b0;
    end
    else
    begin
      unlock_r <= unlock_nxt;
      light_en_r <= light_en_nxt;
      deep_req_r <= deep_req_nxt;
    end
  end

  // ==========================================================================
  // power state machine
  // ==========================================================================
  always_comb
  begin
    state_nxt = state_r;
    cnt_nxt = cnt_r;
    case (state_r)
      alpm_pkg::ALPM_ACTIVE:
      begin
        if (deep_req_r && css_rise)
          state_nxt = alpm_pkg::ALPM_DEEP; // R7
        else if (light_en_r && i_conversion_done && css_s)
          state_nxt = alpm_pkg::ALPM_LIGHT; // R3
      end
      alpm_pkg::ALPM_LIGHT:
      begin
        if (css_fall)
        begin
          state_nxt = alpm_pkg::ALPM_LIGHT_WAKE; // R5
          cnt_nxt = alpm_pkg::CNT_W'(LIGHT_WAKE);
        end
      end
      alpm_pkg::ALPM_LIGHT_WAKE, alpm_pkg::ALPM_DEEP_WAKE:
      begin
        if (cnt_r <= alpm_pkg::CNT_W'(1))
        begin
          state_nxt = alpm_pkg::ALPM_ACTIVE;
          cnt_nxt = '0;
        end
        else
          cnt_nxt = cnt_r - alpm_pkg::CNT_W'(1);
      end
      alpm_pkg::ALPM_DEEP:
      begin
        if (!deep_req_r)
        begin
          state_nxt = alpm_pkg::ALPM_DEEP_WAKE; // R11
          cnt_nxt = alpm_pkg::CNT_W'(DEEP_WAKE);
        end
      end
      default:
      begin
        state_nxt = alpm_pkg::ALPM_ACTIVE;
        cnt_nxt = '0;
      end
    endcase
  end
  always_ff @(posedge i_clock or posedge i_reset)
  begin
    if (i_reset)
    begin
      state_r <= alpm_pkg::ALPM_ACTIVE;
      cnt_r <= '0;
    end
    else
    begin
      state_r <= state_nxt;
      cnt_r <= cnt_nxt;
    end
  end

  // ==========================================================================
  // registered outputs, decoded from next state
  // ==========================================================================
  // analog stays up in active and light sleep; only deep sleep removes it
  always_comb
  begin
    analog_nxt = (state_nxt != alpm_pkg::ALPM_DEEP); // R1 R8
    reduced_nxt = (state_nxt == alpm_pkg::ALPM_LIGHT); // R4
    ready_nxt = (state_nxt == alpm_pkg::ALPM_DEEP) ||
                (state_nxt == alpm_pkg::ALPM_DEEP_WAKE) ||
                (state_nxt == alpm_pkg::ALPM_ACTIVE); // R9 R11
    wake_nxt = (state_nxt == alpm_pkg::ALPM_LIGHT_WAKE) ||
               (state_nxt == alpm_pkg::ALPM_DEEP_WAKE); // R6 R12
    // the serial interface is never powered down, in any mode
    interface_nxt = 1'b1; // R8
  end
  always_ff @(posedge i_clock or posedge i_reset)
  begin
    if (i_reset)
    begin
      analog_r <= 1'b1;
      reduced_r <= 1'b0;
      ready_r <= 1'b1;
      wake_r <= 1'b0;
      interface_r <= 1'b1;
    end
    else
    begin
      analog_r <= analog_nxt;
      reduced_r <= reduced_nxt;
      ready_r <= ready_nxt;
      wake_r <= wake_nxt;
      interface_r <= interface_nxt;
    end
  end
  assign o_analog_power_on = analog_r;
  assign o_reduced_power = reduced_r;
  assign o_interface_on = interface_r; // R8
  assign o_ready_status_output = ready_r;
  assign o_wake_pending = wake_r;
  assign o_light_sleep_enable = light_en_r;
  assign o_deep_sleep_request = deep_req_r;

  // ==========================================================================
  // checks
  // ==========================================================================
  sequence s_deep_armed;
    deep_req_r && state_r == alpm_pkg::ALPM_ACTIVE && css_rise;
  endsequence
  a_deep_entry: assert property (@(posedge i_clock) disable iff (i_reset) // R7
    s_deep_armed |=> state_r == alpm_pkg::ALPM_DEEP ##0 !o_analog_power_on)
    else $error("deep sleep not entered on pin rise");
  a_deep_ready: assert property (@(posedge i_clock) disable iff (i_reset) // R9
    state_r == alpm_pkg::ALPM_DEEP |-> o_ready_status_output)
    else $error("ready low in deep sleep");
  a_deep_exit: assert property (@(posedge i_clock) disable iff (i_reset) // R11
    state_r == alpm_pkg::ALPM_DEEP && !deep_req_r |=> o_ready_status_output && o_wake_pending)
    else $error("deep exit not signalled");
  a_light_entry: assert property (@(posedge i_clock) disable iff (i_reset) // R3
    state_r == alpm_pkg::ALPM_ACTIVE && !deep_req_r && light_en_r && i_conversion_done && css_s
    |=> o_reduced_power)
    else $error("light sleep not entered");
  a_light_exit: assert property (@(posedge i_clock) disable iff (i_reset) // R5
    state_r == alpm_pkg::ALPM_LIGHT && css_fall |=> !o_reduced_power && o_wake_pending)
    else $error("light sleep not left on fall");
  a_light_stay: assert property (@(posedge i_clock) disable iff (i_reset) // R3
    state_r == alpm_pkg::ALPM_LIGHT && css_s |=> state_r == alpm_pkg::ALPM_LIGHT)
    else $error("light sleep left with pin high");
  a_analog_kept: assert property (@(posedge i_clock) disable iff (i_reset) // R1
    state_r == alpm_pkg::ALPM_ACTIVE |-> o_analog_power_on)
    else $error("analog off in normal mode");
  a_locked_write: assert property (@(posedge i_clock) disable iff (i_reset) // R2
    i_reg_write && !unlock_r |=> $stable(deep_req_r) && $stable(light_en_r))
    else $error("power bits changed while locked");
  a_wake_count: assert property (@(posedge i_clock) disable iff (i_reset) // R13
    state_r == alpm_pkg::ALPM_LIGHT && css_fall |=> cnt_r == alpm_pkg::CNT_W'(LIGHT_WAKE))
    else $error("wake count not loaded");
endmodule : alpm_ctrl
`default_nettype wire

// ===== core/alpm_pkg.sv
// alpm_pkg: constants and types of the converter low-power mode controller
package alpm_pkg;
  // ==========================================================================
  // register write port layout
  // ==========================================================================
  localparam int ADDR_W = 8;
  localparam int DATA_W = 8;
  localparam logic [7:0] UNLOCK_ADDR = 8'h05;
  localparam logic [7:0] UNLOCK_VALUE = 8'h69;
  localparam logic [7:0] PWR_CTL_ADDR = 8'h04;
  localparam int LIGHT_EN_BIT = 1;
  localparam int DEEP_REQ_BIT = 0;
  // ==========================================================================
  // wake-up times (default cycles at 25 MHz)
  // ==========================================================================
  localparam int CLK_PERIOD_NS = 40;
  localparam int LIGHT_WAKE_NS = 400;
  localparam int DEEP_WAKE_NS = 10000;
  localparam int LIGHT_WAKE_CYC = (LIGHT_WAKE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int DEEP_WAKE_CYC = (DEEP_WAKE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CNT_W = 16;
  // ==========================================================================
  // power states
  // ==========================================================================
  typedef enum logic [4:0] {
    ALPM_ACTIVE = 5'h01,
    ALPM_LIGHT = 5'h02,
    ALPM_LIGHT_WAKE = 5'h04,
    ALPM_DEEP = 5'h08,
    ALPM_DEEP_WAKE = 5'h10
  } alpm_state_t;
endpackage : alpm_pkg

// ===== core/alpm_sync.sv
// alpm_sync: two flip-flop synchroniser for pin inputs
`timescale 1ns/1ns
`default_nettype none
module alpm_sync
(
  // clock and reset
  input wire logic i_clock,
  input wire logic i_reset,
  // async level in, synchronised level out
  input wire logic i_async,
  output logic o_sync
);
  logic meta_r;
  logic sync_r;
  // ==========================================================================
  // first stage feeds only the second
  // ==========================================================================
  always_ff @(posedge i_clock or posedge i_reset)
  begin
    if (i_reset)
    begin
      meta_r <= 1'b0;
      sync_r <= 1'b0;
    end
    else
    begin
      meta_r <= i_async;
      sync_r <= meta_r;
    end
  end
  assign o_sync = sync_r;
endmodule : alpm_sync
`default_nettype wire

// ===== sim/alpm_host.sv
// alpm_host: host controller model driving the pin and the register write port
`timescale 1ns/1ns
`default_nettype none
module alpm_host
(
  // clock and status from the block
  input wire logic i_clock,
  input wire logic i_wake_pending,
  // pin, conversion core pulse and register port
  output logic o_conversion_start_select,
  output logic o_conversion_done,
  output logic o_reg_write,
  output logic [alpm_pkg::ADDR_W-1:0] o_reg_addr,
  output logic [alpm_pkg::DATA_W-1:0] o_reg_wdata
);
  // idle values at time zero
  initial
  begin
    o_conversion_start_select = 1'b0;
    o_conversion_done = 1'b0;
    o_reg_write = 1'b0;
    o_reg_addr = 8'h00;
    o_reg_wdata = 8'h00;
  end
  // one write; the released bus shows inverted values so stale data never looks valid
  task automatic write_reg(input logic [7:0] addr, input logic [7:0] data);
    @(negedge i_clock);
    o_reg_write = 1'b1;
    o_reg_addr = addr;
    o_reg_wdata = data;
    @(negedge i_clock);
    o_reg_write = 1'b0;
    o_reg_addr = ~addr;
    o_reg_wdata = ~data;
  endtask : write_reg
  // unlock, then the power-control word as the very next write
  task automatic set_power(input logic light, input logic deep);
    logic [7:0] word;
    word = 8'h00;
    word[alpm_pkg::LIGHT_EN_BIT] = light;
    word[alpm_pkg::DEEP_REQ_BIT] = deep;
    write_reg(alpm_pkg::UNLOCK_ADDR, alpm_pkg::UNLOCK_VALUE);
    write_reg(alpm_pkg::PWR_CTL_ADDR, word);
  endtask : set_power
  // pin level and a one-cycle end-of-conversion pulse
  task automatic set_pin(input logic level);
    @(negedge i_clock);
    o_conversion_start_select = level;
  endtask : set_pin
  task automatic pulse_done();
    @(negedge i_clock);
    o_conversion_done = 1'b1;
    @(negedge i_clock);
    o_conversion_done = 1'b0;
  endtask : pulse_done
  // no new conversion until the wake count has run out; bounded so a hang is caught
  task automatic wait_wake(input logic level, input int lim, output bit ok);
    ok = 1'b0;
    for (int n = 0; n < lim && !ok; n++)
    begin
      @(negedge i_clock);
      ok = (i_wake_pending === level);
    end
  endtask : wait_wake
endmodule : alpm_host
`default_nettype wire

// ===== sim/alpm_ctrl_tb.sv
// alpm_ctrl_tb: self-checking bench of the low-power mode controller
`timescale 1ns/1ns
`default_nettype none
module alpm_ctrl_tb;
  // ==========================================================================
  // short wake counts keep the run brief
  // ==========================================================================
  localparam int LIGHT_WAKE = 3;
  localparam int DEEP_WAKE = 5;
  logic i_clock;
  logic i_reset;
  logic pin, done, wr, an_on, reduced, if_on, ready, wake, light, deep;
  logic [7:0] addr, wdata;
  int miscompares;
  int total_checks;
  alpm_host alpm_host_i (.i_clock(i_clock), .i_wake_pending(wake),
    .o_conversion_start_select(pin), .o_conversion_done(done), .o_reg_write(wr),
    .o_reg_addr(addr), .o_reg_wdata(wdata));
  alpm_ctrl #(.LIGHT_WAKE(LIGHT_WAKE), .DEEP_WAKE(DEEP_WAKE)) alpm_ctrl_i (.i_clock(i_clock),
    .i_reset(i_reset), .i_conversion_start_select(pin), .i_conversion_done(done),
    .i_reg_write(wr), .i_reg_addr(addr), .i_reg_wdata(wdata), .o_analog_power_on(an_on),
    .o_reduced_power(reduced), .o_interface_on(if_on), .o_ready_status_output(ready),
    .o_wake_pending(wake), .o_light_sleep_enable(light), .o_deep_sleep_request(deep));
  // 25 MHz clock
  initial
  begin
    i_clock = 1'b0;
    forever #20 i_clock = ~i_clock;
  end
  // ==========================================================================
  // compare, wait and closing tasks
  // ==========================================================================
  task automatic check(input string what, input logic exp, input logic got);
    total_checks++;
    if (got !== exp)
    begin
      $display("mismatch %s expected %b seen %b", what, exp, got);
      miscompares++;
    end
  endtask : check
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : end_of_test
  task automatic wait_wake(input logic level, input int lim);
    bit ok;
    alpm_host_i.wait_wake(level, lim, ok);
    total_checks++;
    if (!ok)
    begin
      $display("mismatch wake_pending expected %b seen %b", level, wake);
      miscompares++;
      end_of_test();
    end
  endtask : wait_wake
  task automatic idle(input int n);
    repeat (n) @(negedge i_clock);
  endtask : idle
  // ==========================================================================
  // scenarios
  // ==========================================================================
  task automatic test_reset();
    check("analog_on", 1'b1, an_on);
    check("reduced", 1'b0, reduced);
    check("interface_on", 1'b1, if_on);
    check("ready", 1'b1, ready);
    check("wake", 1'b0, wake);
  endtask : test_reset
  // locked writes and a relock by an intervening write are both ignored
  task automatic test_locked();
    alpm_host_i.write_reg(alpm_pkg::PWR_CTL_ADDR, 8'h03);
    alpm_host_i.write_reg(alpm_pkg::UNLOCK_ADDR, alpm_pkg::UNLOCK_VALUE);
    alpm_host_i.write_reg(alpm_pkg::UNLOCK_ADDR, 8'h00);
    alpm_host_i.write_reg(alpm_pkg::PWR_CTL_ADDR, 8'h03);
    idle(2);
    check("light_bit", 1'b0, light);
    check("deep_bit", 1'b0, deep);
  endtask : test_locked
  // with light sleep off, a conversion end keeps everything powered
  task automatic test_normal();
    alpm_host_i.set_pin(1'b1);
    idle(4);
    alpm_host_i.pulse_done();
    idle(4);
    check("reduced", 1'b0, reduced);
    check("analog_on", 1'b1, an_on);
    check("wake", 1'b0, wake);
    alpm_host_i.set_pin(1'b0);
  endtask : test_normal
  task automatic test_light();
    alpm_host_i.set_power(1'b1, 1'b0);
    idle(2);
    check("light_bit", 1'b1, light);
    alpm_host_i.set_pin(1'b1);
    idle(4);
    alpm_host_i.pulse_done();
    idle(3);
    check("reduced", 1'b1, reduced);
    idle(8);
    check("reduced held", 1'b1, reduced);
    check("analog_on", 1'b1, an_on);
    check("ready in light sleep", 1'b0, ready);
    alpm_host_i.set_pin(1'b0);
    idle(3);
    check("reduced after fall", 1'b0, reduced);
    check("wake after fall", 1'b1, wake);
    wait_wake(1'b0, LIGHT_WAKE + 4);
  endtask : test_light
  task automatic test_deep();
    alpm_host_i.set_power(1'b1, 1'b1);
    idle(2);
    check("deep_bit", 1'b1, deep);
    check("analog_on before rise", 1'b1, an_on);
    alpm_host_i.set_pin(1'b1);
    idle(6);
    check("analog_on", 1'b0, an_on);
    check("interface_on", 1'b1, if_on);
    check("light_bit kept", 1'b1, light);
    check("ready", 1'b1, ready);
    alpm_host_i.set_power(1'b1, 1'b0);
    wait_wake(1'b1, 4);
    check("ready on exit", 1'b1, ready);
    check("analog_on on exit", 1'b1, an_on);
    wait_wake(1'b0, DEEP_WAKE + 4);
    alpm_host_i.set_pin(1'b0);
  endtask : test_deep
  // a reset in mid-run drops deep sleep and the request; the pin, still high,
  // must then not re-enter deep sleep
  task automatic test_mid_reset();
    alpm_host_i.set_power(1'b0, 1'b1);
    alpm_host_i.set_pin(1'b1);
    idle(6);
    check("analog_on in deep", 1'b0, an_on);
    i_reset = 1'b1;
    idle(2);
    i_reset = 1'b0;
    idle(1);
    check("deep_bit after reset", 1'b0, deep);
    check("analog_on after reset", 1'b1, an_on);
    check("ready after reset", 1'b1, ready);
    check("wake after reset", 1'b0, wake);
    idle(4);
    check("analog_on pin still high", 1'b1, an_on);
    alpm_host_i.set_pin(1'b0);
  endtask : test_mid_reset
  // main sequence
  initial
  begin
    miscompares = 0;
    total_checks = 0;
    i_reset = 1'b1;
    idle(10);
    i_reset = 1'b0;
    idle(1);
    test_reset();
    test_locked();
    test_normal();
    test_light();
    test_deep();
    test_mid_reset();
    end_of_test();
  end
endmodule : alpm_ctrl_tb
`default_nettype wire
